// ==== charge_policy_pkg.sv ====
package charge_policy_pkg;

  // voltage codes are in 100 mV units
  localparam logic [7:0] V_DEFAULT = 8'h32;
  localparam logic [7:0] V_MIN = 8'h24;
  localparam logic [7:0] V_CAP_FLOAT = 8'h78;
  localparam logic [7:0] V_CAP_GND = 8'hC8;
  // feedback code is signed, 2 uA a step
  localparam int FB_W = 9;
  localparam logic [FB_W-1:0] FB_ZERO = 9'h000;

  // register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_TRIM = 8'h04;
  localparam logic [7:0] ADDR_ILIM = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
  localparam logic [7:0] ADDR_LAST_REQ = 8'h18;

  // field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_LEGACY_EN = 1;
  localparam int IRQ_GRANT = 0;
  localparam int IRQ_DENY = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_MODE = 3;
  localparam int IRQ_RAIL = 4;
  localparam int IRQ_W = 5;

  // reset values
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam logic [FB_W-1:0] TRIM_RST = 9'h000;
  localparam logic [7:0] ILIM_RST = 8'h1E;
  localparam logic [IRQ_W-1:0] MASK_RST = 5'h00;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {CAP_5V, CAP_12V, CAP_20V} cap_t;

  // analog comparator outputs, asynchronous to aclk
  typedef struct packed {
    logic sel_high;
    logic sel_gnd;
    logic ntc_below_short;
    logic ntc_below_hot;
    logic ntc_above_cold;
    logic cc_sink_attached;
  } cmp_in_t;

  // request from the line protocol decoder
  typedef struct packed {
    logic [2:0] standard;
    logic [7:0] volt;
    logic [7:0] amps;
  } req_t;

endpackage : charge_policy_pkg

// ==== fast_charge_policy_control.sv ====
`timescale 1ns/1ps
module fast_charge_policy_control
  import charge_policy_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // comparators
  input wire cmp_in_t cmp_in,
  // protocol decoder side
  input wire logic req_valid,
  input wire req_t req,
  input wire logic handshake_ok,
  input wire logic client_legacy,
  output logic req_grant,
  output logic req_deny,
  // pins and analog controls
  output logic temp_fault_flag,
  output logic current_sense_mode,
  output logic rail_enable,
  output logic cc_source_en,
  output logic dpdm_legacy_en,
  output logic [FB_W-1:0] feedback_current,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // comparator synchronisers

  localparam int NSYNC = $bits(cmp_in_t);
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  cmp_in_t cmp_s;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
    end
    else
    begin
      sync1_r <= cmp_in;
      sync2_r <= sync1_r;
    end
  end

  assign cmp_s = cmp_in_t'(sync2_r);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [1:0] ctrl_r;
  logic [FB_W-1:0] trim_r;
  logic [7:0] ilim_r;
  logic [IRQ_W-1:0] irq_stat_r;
  logic [IRQ_W-1:0] irq_mask_r;
  req_t last_req_r;
  logic [7:0] volt_r;
  logic [FB_W-1:0] fb_r;
  logic fault_r;
  logic cs_mode_r;
  logic rail_r;
  cap_t cap;
  logic [7:0] cap_volt;
  logic fault_nxt;
  logic cs_mode_nxt;
  logic [IRQ_W-1:0] events;

  ////////////////////////////////////////////////////////////////////////
  // voltage cap and mode

  always_comb
  begin
    if (cmp_s.sel_high)
    begin
      cap = CAP_5V;
      cap_volt = V_DEFAULT;
    end
    else if (cmp_s.sel_gnd)
    begin
      cap = CAP_20V;
      cap_volt = V_CAP_GND;
    end
    else
    begin
      cap = CAP_12V;
      cap_volt = V_CAP_FLOAT;
    end
  end

  // the mode follows the pin level; a shorted thermistor therefore reads as current-sense
  assign cs_mode_nxt = cmp_s.ntc_below_short;
  // cold side, hot window, otherwise normal; always clear in current-sense mode
  assign fault_nxt = !cs_mode_nxt && (cmp_s.ntc_above_cold
                     || cmp_s.ntc_below_hot);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cs_mode_r <= 1'b0;
      fault_r <= 1'b0;
    end
    else
    begin
      cs_mode_r <= cs_mode_nxt;
      fault_r <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // request arbitration and feedback current

  logic req_ok;
  logic [7:0] volt_grant;
  logic signed [FB_W-1:0] fb_base;
  logic signed [FB_W-1:0] fb_calc;

  // 10 uA per volt above 5 V gives 40, 70 and 150 uA at 9, 12 and 20 V
  assign fb_base = FB_W'(($signed({1'b0, req.volt}) - $signed({1'b0, V_DEFAULT})) >>> 1);
  assign fb_calc = fb_base + $signed(trim_r);

  always_comb
  begin
    req_ok = ctrl_r[CTRL_EN] && !cmp_s.sel_high;
    if (req.volt > cap_volt || req.volt < V_MIN)
      req_ok = 1'b0;
    if (req.amps > ilim_r)
      req_ok = 1'b0;
    // the current-sense protocol is unavailable in thermistor mode
    if (req.standard == 3'h0 || (req.standard == 3'h7 && !cs_mode_r))
      req_ok = 1'b0;
    volt_grant = req.volt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      req_grant <= 1'b0;
      req_deny <= 1'b0;
      volt_r <= V_DEFAULT;
      fb_r <= FB_ZERO;
      last_req_r <= '0;
    end
    else
    begin
      req_grant <= req_valid && req_ok;
      req_deny <= req_valid && !req_ok;
      if (req_valid)
        last_req_r <= req;
      if (cmp_s.sel_high || !ctrl_r[CTRL_EN])
      begin
        volt_r <= V_DEFAULT;
        fb_r <= FB_ZERO;
      end
      else if (req_valid && req_ok)
      begin
        volt_r <= volt_grant;
        fb_r <= (volt_grant == V_DEFAULT) ? FB_ZERO : fb_calc;
      end
      else if (volt_r > cap_volt)
      begin
        // cap lowered under a running grant: fall back to default
        volt_r <= V_DEFAULT;
        fb_r <= FB_ZERO;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // type-c rail, cc and dp/dm

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rail_r <= 1'b0;
    else if (!cmp_s.cc_sink_attached)
      rail_r <= 1'b0;
    else if (handshake_ok)
      rail_r <= 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cc_source_en <= 1'b0;
      dpdm_legacy_en <= 1'b0;
    end
    else
    begin
      cc_source_en <= rail_r;
      dpdm_legacy_en <= ctrl_r[CTRL_LEGACY_EN] && client_legacy;
    end
  end

  assign temp_fault_flag = fault_r;
  assign current_sense_mode = cs_mode_r;
  assign rail_enable = rail_r;
  assign feedback_current = fb_r;

  ////////////////////////////////////////////////////////////////////////
  // interrupts

  logic fault_d_r;
  logic mode_d_r;
  logic rail_d_r;
  logic wr_fire;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fault_d_r <= 1'b0;
      mode_d_r <= 1'b0;
      rail_d_r <= 1'b0;
    end
    else
    begin
      fault_d_r <= fault_r;
      mode_d_r <= cs_mode_r;
      rail_d_r <= rail_r;
    end
  end

  always_comb
  begin
    events = '0;
    events[IRQ_GRANT] = req_grant;
    events[IRQ_DENY] = req_deny;
    events[IRQ_FAULT] = fault_r && !fault_d_r;
    events[IRQ_MODE] = cs_mode_r ^ mode_d_r;
    events[IRQ_RAIL] = rail_r && !rail_d_r;
  end

  // a new event wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_r <= '0;
    else if (wr_fire && wr_addr == ADDR_IRQ_STAT && w_strb_r[0])
      irq_stat_r <= (irq_stat_r & ~wr_data[IRQ_W-1:0]) | events;
    else
      irq_stat_r <= irq_stat_r | events;
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite write

  logic aw_have_r;
  logic w_have_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic wr_mapped;

  assign s_axi_awready = !aw_have_r && !s_axi_bvalid;
  assign s_axi_wready = !w_have_r && !s_axi_bvalid;
  assign wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_addr = aw_addr_r;
  assign wr_data = w_data_r;
  assign wr_mapped = wr_addr == ADDR_CTRL || wr_addr == ADDR_TRIM || wr_addr == ADDR_ILIM
                     || wr_addr == ADDR_IRQ_STAT || wr_addr == ADDR_IRQ_MASK || wr_addr == ADDR_STATUS
                     || wr_addr == ADDR_LAST_REQ;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have_r <= 1'b1;
        aw_addr_r <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // only byte lane 0 is writable except the trim, which spans two
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_r <= CTRL_RST;
      trim_r <= TRIM_RST;
      ilim_r <= ILIM_RST;
      irq_mask_r <= MASK_RST;
    end
    else if (wr_fire)
    begin
      if (wr_addr == ADDR_CTRL && w_strb_r[0])
        ctrl_r <= wr_data[1:0];
      if (wr_addr == ADDR_TRIM && w_strb_r[0])
        trim_r[7:0] <= wr_data[7:0];
      if (wr_addr == ADDR_TRIM && w_strb_r[1])
        trim_r[8] <= wr_data[8];
      if (wr_addr == ADDR_ILIM && w_strb_r[0])
        ilim_r <= wr_data[7:0];
      if (wr_addr == ADDR_IRQ_MASK && w_strb_r[0])
        irq_mask_r <= wr_data[IRQ_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // axi4-lite read

  logic [31:0] rd_mux;
  logic rd_ok;
  logic [7:0] rd_addr;

  assign s_axi_arready = !s_axi_rvalid;
  assign rd_addr = {s_axi_araddr[7:2], 2'b00};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_addr)
      ADDR_CTRL: rd_mux[1:0] = ctrl_r;
      ADDR_TRIM: rd_mux[FB_W-1:0] = trim_r;
      ADDR_ILIM: rd_mux[7:0] = ilim_r;
      ADDR_STATUS: rd_mux = {fb_r, volt_r, 8'h00, cap, cc_source_en, rail_r, dpdm_legacy_en, cs_mode_r, fault_r};
      ADDR_IRQ_STAT: rd_mux[IRQ_W-1:0] = irq_stat_r;
      ADDR_IRQ_MASK: rd_mux[IRQ_W-1:0] = irq_mask_r;
      ADDR_LAST_REQ: rd_mux[18:0] = last_req_r;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

endmodule : fast_charge_policy_control

// ==== fast_charge_policy_control_sva.sv ====
`timescale 1ns/1ps
module fast_charge_policy_control_sva
  import charge_policy_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // inputs
  input wire cmp_in_t cmp_in,
  input wire logic req_valid,
  input wire req_t req,
  input wire logic handshake_ok,
  // outputs
  input wire logic req_grant,
  input wire logic req_deny,
  input wire logic temp_fault_flag,
  input wire logic current_sense_mode,
  input wire logic rail_enable,
  input wire logic cc_source_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////
  // levels must be held long enough to cross the two sync flops
  sequence s_float_over;
    (!cmp_in.sel_high && !cmp_in.sel_gnd)[*3] ##0 (req_valid && req.volt > V_CAP_FLOAT);
  endsequence
  sequence s_attach_hs;
    cmp_in.cc_sink_attached[*3] ##0 handshake_ok;
  endsequence

  a_one_answer: assert property (req_valid |=> req_grant ^ req_deny)
    else $error("request not answered once");
  a_sel_high_deny: assert property (cmp_in.sel_high[*3] ##0 req_valid |=> req_deny)
    else $error("request granted with select high");
  a_float_cap: assert property (s_float_over |=> req_deny)
    else $error("request over 12 V granted");
  a_cold_fault: assert property ((!cmp_in.ntc_below_short && cmp_in.ntc_above_cold)[*4] |-> temp_fault_flag)
    else $error("cold fault missing");
  a_hot_fault: assert property ((!cmp_in.ntc_below_short && cmp_in.ntc_below_hot)[*4] |-> temp_fault_flag)
    else $error("hot fault missing");
  a_normal_clear: assert property ((!cmp_in.ntc_below_hot && !cmp_in.ntc_above_cold)[*4] |-> !temp_fault_flag)
    else $error("fault in normal range");
  a_sense_mode: assert property (cmp_in.ntc_below_short[*4] |-> current_sense_mode && !temp_fault_flag)
    else $error("sense mode wrong");
  a_rail_on: assert property (s_attach_hs |=> rail_enable ##1 cc_source_en)
    else $error("rail or cc source late");
endmodule : fast_charge_policy_control_sva

bind fast_charge_policy_control fast_charge_policy_control_sva u_sva (.aclk, .aresetn, .cmp_in, .req_valid,
  .req, .handshake_ok, .req_grant, .req_deny, .temp_fault_flag, .current_sense_mode, .rail_enable, .cc_source_en);

// ==== charge_client_model.sv ====
`timescale 1ns/1ps
module charge_client_model
  import charge_policy_pkg::*;
(
  // clock
  input wire logic aclk,
  // pin levels set by the bench
  input int ntc_mv,
  input wire logic [1:0] sel_pin,
  input wire logic attached,
  // device answers
  input wire logic req_grant,
  input wire logic req_deny,
  // to the device
  output cmp_in_t cmp_in,
  output logic req_valid,
  output req_t req
);
  // sel_pin: 0 grounded, 1 floating, 2 pulled high
  assign cmp_in = '{sel_pin == 2'h2, sel_pin == 2'h0, ntc_mv < 100, ntc_mv < 500, ntc_mv > 1500, attached};

  initial
  begin
    req_valid = 1'b0;
    req = '0;
  end

  // idle request bus shows the inverse so a stale value is never trusted
  task automatic send(input logic [2:0] s, input logic [7:0] v, output logic [1:0] gd);
    @(posedge aclk);
    req_valid <= 1'b1;
    req <= '{s, v, 8'h14};
    @(posedge aclk);
    req_valid <= 1'b0;
    req <= ~req;
    @(posedge aclk);
    gd = {req_grant, req_deny};
  endtask : send
endmodule : charge_client_model

// ==== test_fast_charge_policy_control.sv ====
`timescale 1ns/1ps
module test_fast_charge_policy_control import charge_policy_pkg::*;;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, req_valid, req_grant;
  logic req_deny, handshake_ok, client_legacy, temp_fault_flag, current_sense_mode, rail_enable;
  logic cc_source_en, dpdm_legacy_en, irq, attached;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, sel_pin, gd;
  logic [FB_W-1:0] feedback_current;
  cmp_in_t cmp_in;
  req_t req;
  int ntc_mv, bad_count, n_checks;
  int mv[5] = '{1000, 1800, 300, 50, 700};
  logic [1:0] fm[5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h0};
  logic [7:0] vt[4] = '{8'h5A, 8'h78, 8'hC8, 8'h32};
  logic [8:0] fb[4] = '{9'h014, 9'h023, 9'h04B, 9'h000};

  fast_charge_policy_control u_fast_charge_policy_control (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .cmp_in, .req_valid, .req, .handshake_ok, .client_legacy, .req_grant, .req_deny,
    .temp_fault_flag, .current_sense_mode, .rail_enable, .cc_source_en, .dpdm_legacy_en, .feedback_current, .irq);
  charge_client_model u_charge_client_model (.aclk, .ntc_mv, .sel_pin, .attached, .req_grant, .req_deny,
    .cmp_in, .req_valid, .req);

  ////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc

  // address and data are released separately as each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic pa;
    logic pw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    pa = 1'b1;
    pw = 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    check(s_axi_bresp, er);
  endtask : wr

  task automatic rchk(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    check(s_axi_rresp, er);
    if (er == RESP_OKAY) check(s_axi_rdata, ed);
  endtask : rchk

  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  ////////////////////////////////////////////////////////////
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  initial
  begin
    #40000;
    bad_count++;
    complete_run();
  end

  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, handshake_ok, client_legacy, attached, sel_pin} = '0;
    s_axi_wstrb = 4'hF;
    ntc_mv = 1000;
    cyc(16);
    aresetn <= 1'b1;
    rchk(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    rchk(ADDR_TRIM, 32'h0000_0000, RESP_OKAY);
    rchk(ADDR_ILIM, 32'h0000_001E, RESP_OKAY);
    rchk(ADDR_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    rchk(8'h1C, 32'h0000_0000, RESP_SLVERR);
    wr(8'h1C, 32'h0000_0001, RESP_SLVERR);
    foreach (mv[i])
    begin
      ntc_mv <= mv[i];
      cyc(4);
      check({current_sense_mode, temp_fault_flag}, fm[i]);
    end
    foreach (vt[i])
    begin
      u_charge_client_model.send(3'h1, vt[i], gd);
      check(gd, 2'h2);
      check(feedback_current, fb[i]);
    end
    u_charge_client_model.send(3'h1, 8'h23, gd);
    check(gd, 2'h1);
    wr(ADDR_ILIM, 32'h0000_0010, RESP_OKAY);
    u_charge_client_model.send(3'h1, 8'h5A, gd);
    check(gd, 2'h1);
    wr(ADDR_ILIM, 32'h0000_001E, RESP_OKAY);
    // negative trim sinks relative to the nominal code
    wr(ADDR_TRIM, 32'h0000_01FD, RESP_OKAY);
    u_charge_client_model.send(3'h1, 8'h5A, gd);
    check(feedback_current, 9'h011);
    wr(ADDR_TRIM, 32'h0000_0000, RESP_OKAY);
    for (int s = 0; s < 8; s++)
    begin
      u_charge_client_model.send(s[2:0], 8'h5A, gd);
      check(gd, (s == 0 || s == 7) ? 2'h1 : 2'h2);
    end
    ntc_mv <= 0;
    cyc(4);
    u_charge_client_model.send(3'h7, 8'h5A, gd);
    check(gd, 2'h2);
    ntc_mv <= 700;
    u_charge_client_model.send(3'h1, 8'h78, gd);
    check(gd, 2'h2);
    sel_pin <= 2'h1;
    cyc(3);
    u_charge_client_model.send(3'h1, 8'hC8, gd);
    check(gd, 2'h1);
    check(feedback_current, 9'h023);
    rchk(ADDR_STATUS, 32'h11BC_0020, RESP_OKAY);
    rchk(ADDR_LAST_REQ, 32'h0001_C814, RESP_OKAY);
    sel_pin <= 2'h2;
    cyc(4);
    check(feedback_current, 9'h000);
    u_charge_client_model.send(3'h1, 8'h5A, gd);
    check(gd, 2'h1);
    wr(ADDR_IRQ_MASK, 32'h0000_0001, RESP_OKAY);
    check(irq, 1'b1);
    wr(ADDR_IRQ_STAT, 32'h0000_0001, RESP_OKAY);
    check(irq, 1'b0);
    sel_pin <= 2'h0;
    cyc(3);
    u_charge_client_model.send(3'h1, 8'h5A, gd);
    check(gd, 2'h2);
    // the status bit is set one edge after the grant pulse
    cyc(1);
    check(irq, 1'b1);
    wr(ADDR_IRQ_MASK, 32'h0000_0000, RESP_OKAY);
    check(irq, 1'b0);
    wr(ADDR_CTRL, 32'h0000_0002, RESP_OKAY);
    u_charge_client_model.send(3'h1, 8'h5A, gd);
    check(gd, 2'h1);
    check(feedback_current, 9'h000);
    wr(ADDR_CTRL, 32'h0000_0003, RESP_OKAY);
    attached <= 1'b1;
    cyc(3);
    handshake_ok <= 1'b1;
    cyc(1);
    handshake_ok <= 1'b0;
    cyc(1);
    check({rail_enable, cc_source_en}, 2'h2);
    cyc(1);
    check({rail_enable, cc_source_en}, 2'h3);
    attached <= 1'b0;
    cyc(4);
    check(rail_enable, 1'b0);
    client_legacy <= 1'b1;
    cyc(4);
    check(dpdm_legacy_en, 1'b1);
    client_legacy <= 1'b0;
    cyc(4);
    check(dpdm_legacy_en, 1'b0);
    complete_run();
  end
endmodule : test_fast_charge_policy_control
